// >>> verilog/converter_byte_handshake_port.v
// Functional notes
// - latch with request high enters after latch
// - request rise enters now, else after latch
// - handshake blocks latching, ignores request
// - steady request: every conversion latched outside handshake starts handshake
// - disable pins become outputs during handshake
// - ready sensed once per converter period
// - ready high: enable byte, strobe one period
// - falling edge with ready floats the byte
// - half period later raise disable, next byte
// - three groups, or two for short versions
// - final acknowledge leaves handshake mode
// - request low after handshake releases disable pins
// - inactive disable lines rely on pull-ups
// - result delivered as consecutive words of at most 8 bits
// - 18 lines split in groups of eight, eight and two
`timescale 1ns/1ns
`default_nettype none
`include "hs_port_map.vh"

module converter_byte_handshake_port (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	input wire clk_en,
	// conversion side
	input wire result_latch,
	input wire [`RESULT_BITS-1:0] result_in,
	input wire short_version,
	input wire handshake_req,
	// converter phase clock
	output reg converter_phase_clock,
	// handshake pins
	input wire receiver_ready_in,
	input wire chip_disable_load_strobe_in,
	output reg chip_disable_load_strobe_out,
	output reg chip_disable_load_strobe_oe,
	input wire [`GROUP_COUNT-1:0] byte_disable_in,
	output reg [`GROUP_COUNT-1:0] byte_disable_out,
	output reg [`GROUP_COUNT-1:0] byte_disable_oe,
	// result bus
	output wire [`RESULT_BITS-1:0] data_out,
	output wire [`RESULT_BITS-1:0] data_oe,
	// status
	output reg handshake_active
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_WAIT = 5'h02;
	localparam [4:0] ST_STROBE = 5'h04;
	localparam [4:0] ST_HOLD = 5'h08;
	localparam [4:0] ST_FLOAT = 5'h10;

	reg [4:0] state_q;
	reg [4:0] state_d;
	reg [1:0] group_q;
	reg [1:0] group_d;
	reg [`GROUP_COUNT-1:0] drive_q;
	reg [`GROUP_COUNT-1:0] drive_d;
	reg [`GROUP_COUNT-1:0] bd_d;
	reg ld_d;
	reg [1:0] strobe_cnt_q;
	reg [1:0] strobe_cnt_d;
	reg req_prev_q;
	reg pend_q;
	reg pend_d;
	reg hs_d;
	reg release_d;
	wire req_rise;
	wire enter;
	wire rise_evt;
	wire fall_evt;
	wire last_group;
	wire load_ok;

	// ----------------------------------------
	// converter clock phase
	// ----------------------------------------
	// next ref_clk edge is a converter rising edge when the phase is low
	assign rise_evt = ~converter_phase_clock;
	assign fall_evt = converter_phase_clock;

	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			converter_phase_clock <= `PHASE_RST;
		else if (clk_en)
			converter_phase_clock <= ~converter_phase_clock;
	end

	// ----------------------------------------
	// entry into handshake mode
	// ----------------------------------------
	assign req_rise = handshake_req & ~req_prev_q;
	assign load_ok = result_latch & ~handshake_active;
	assign enter = ~handshake_active & ~result_latch & (pend_q | req_rise);
	assign last_group = short_version ? (group_q == `LAST_GROUP_SHORT) :
		(group_q == `LAST_GROUP_FULL);

	always @* begin
		pend_d = pend_q;
		if (handshake_active)
			pend_d = 1'b0;
		else if (result_latch & handshake_req)
			pend_d = 1'b1;
		else if (enter)
			pend_d = 1'b0;
	end

	// ----------------------------------------
	// byte sequencer
	// ----------------------------------------
	always @* begin
		state_d = state_q;
		group_d = group_q;
		drive_d = drive_q;
		bd_d = byte_disable_out;
		ld_d = chip_disable_load_strobe_out;
		strobe_cnt_d = strobe_cnt_q;
		hs_d = handshake_active;
		release_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (enter) begin
					hs_d = 1'b1;
					group_d = `GROUP_RST;
					bd_d = `BYTE_DIS_RST;
					ld_d = `STROBE_RST;
					state_d = ST_WAIT;
				end else if (~handshake_req) begin
					release_d = 1'b1;
				end
			end
			ST_WAIT: begin
				if (rise_evt & receiver_ready_in) begin
					drive_d = 3'h0;
					drive_d[group_q] = 1'b1;
					bd_d[group_q] = 1'b0;
					ld_d = 1'b0;
					strobe_cnt_d = 2'h0;
					state_d = ST_STROBE;
				end
			end
			ST_STROBE: begin
				strobe_cnt_d = strobe_cnt_q + 2'h1;
				if (strobe_cnt_q == `STROBE_CYCLES - 1) begin
					ld_d = 1'b1;
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (fall_evt & receiver_ready_in) begin
					drive_d = 3'h0;
					state_d = ST_FLOAT;
				end
			end
			ST_FLOAT: begin
				bd_d[group_q] = 1'b1;
				if (last_group) begin
					hs_d = 1'b0;
					state_d = ST_IDLE;
				end else begin
					group_d = group_q + 2'h1;
					drive_d[group_q + 2'h1] = 1'b1;
					bd_d[group_q + 2'h1] = 1'b0;
					ld_d = 1'b0;
					strobe_cnt_d = 2'h0;
					state_d = ST_STROBE;
				end
			end
			default: begin
				state_d = ST_IDLE;
				hs_d = 1'b0;
				drive_d = 3'h0;
			end
		endcase
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			group_q <= `GROUP_RST;
			drive_q <= 3'h0;
			strobe_cnt_q <= 2'h0;
			req_prev_q <= 1'b0;
			pend_q <= 1'b0;
			handshake_active <= 1'b0;
			byte_disable_out <= `BYTE_DIS_RST;
			chip_disable_load_strobe_out <= `STROBE_RST;
			byte_disable_oe <= 3'h0;
			chip_disable_load_strobe_oe <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			group_q <= group_d;
			drive_q <= drive_d;
			strobe_cnt_q <= strobe_cnt_d;
			req_prev_q <= handshake_req;
			pend_q <= pend_d;
			handshake_active <= hs_d;
			byte_disable_out <= bd_d;
			chip_disable_load_strobe_out <= ld_d;
			if (hs_d) begin
				byte_disable_oe <= 3'h7;
				chip_disable_load_strobe_oe <= 1'b1;
			end else if (release_d) begin
				// lines float high on their pull-ups
				byte_disable_oe <= 3'h0;
				chip_disable_load_strobe_oe <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// byte groups
	// ----------------------------------------
	byte_lane #(.WIDTH(`GROUP_BITS)) lane0 (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.load(load_ok),
		.d_in(result_in[7:0]),
		.hs_mode(handshake_active),
		.hs_drive(drive_d[0]),
		.chip_dis_in(chip_disable_load_strobe_in),
		.byte_dis_in(byte_disable_in[0]),
		.data_out(data_out[7:0]),
		.data_oe(data_oe[0])
	);

	byte_lane #(.WIDTH(`GROUP_BITS)) lane1 (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.load(load_ok),
		.d_in(result_in[15:8]),
		.hs_mode(handshake_active),
		.hs_drive(drive_d[1]),
		.chip_dis_in(chip_disable_load_strobe_in),
		.byte_dis_in(byte_disable_in[1]),
		.data_out(data_out[15:8]),
		.data_oe(data_oe[8])
	);

	byte_lane #(.WIDTH(`GROUP2_BITS)) lane2 (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.load(load_ok),
		.d_in(result_in[17:16]),
		.hs_mode(handshake_active),
		.hs_drive(drive_d[2]),
		.chip_dis_in(chip_disable_load_strobe_in),
		.byte_dis_in(byte_disable_in[2]),
		.data_out(data_out[17:16]),
		.data_oe(data_oe[16])
	);

	assign data_oe[7:1] = {7{data_oe[0]}};
	assign data_oe[15:9] = {7{data_oe[8]}};
	assign data_oe[17] = data_oe[16];

endmodule

`default_nettype wire

// >>> verilog/hs_port_map.vh
`ifndef HS_PORT_MAP_VH
`define HS_PORT_MAP_VH

// ----------------------------------------
// result bus layout
// ----------------------------------------
`define RESULT_BITS 18
`define GROUP_BITS 8
`define GROUP2_BITS 2
`define GROUP_COUNT 3
`define GROUP_COUNT_SHORT 2
`define LAST_GROUP_FULL 2'h2
`define LAST_GROUP_SHORT 2'h1

// ----------------------------------------
// reset values
// ----------------------------------------
`define PHASE_RST 1'b0
`define STROBE_RST 1'b1
`define BYTE_DIS_RST 3'h7
`define GROUP_RST 2'h0

// ----------------------------------------
// timing counts in ref_clk cycles
// ----------------------------------------
`define HALF_PERIOD_CYCLES 1
`define STROBE_CYCLES 2

`endif

// >>> verilog/byte_lane.v
`timescale 1ns/1ns
`default_nettype none

module byte_lane #(
	parameter WIDTH = 8
) (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	input wire clk_en,
	// data capture
	input wire load,
	input wire [WIDTH-1:0] d_in,
	// enable control
	input wire hs_mode,
	input wire hs_drive,
	input wire chip_dis_in,
	input wire byte_dis_in,
	// bus pins
	output reg [WIDTH-1:0] data_out,
	output reg data_oe
);

	// ----------------------------------------
	// latched data and three-state control
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			data_out <= {WIDTH{1'b0}};
			data_oe <= 1'b0;
		end else if (clk_en) begin
			if (load)
				data_out <= d_in;
			if (hs_mode)
				data_oe <= hs_drive;
			else
				data_oe <= ~chip_dis_in & ~byte_dis_in;
		end
	end

endmodule

`default_nettype wire

// >>> testbench/hs_port_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module hs_port_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic short_version,
	input wire logic converter_phase_clock,
	input wire logic receiver_ready_in,
	input wire logic chip_disable_load_strobe_out,
	input wire logic chip_disable_load_strobe_oe,
	input wire logic [2:0] byte_disable_out,
	input wire logic [2:0] byte_disable_oe,
	input wire logic [17:0] data_out,
	input wire logic [17:0] data_oe,
	input wire logic handshake_active
);
	wire sb = chip_disable_load_strobe_out;
	wire [2:0] bd = byte_disable_out;
	wire ha = handshake_active;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_pulse_end;
		!sb ##1 sb;
	endsequence
	sequence s_next_group;
		!bd[1] && !sb;
	endsequence
	a_strobe_two_cycles: assert property ($fell(sb) |=> s_pulse_end)
		else $error("strobe width");
	a_strobe_one_byte: assert property ($fell(sb) |-> ha && $countones(~bd) == 1 && converter_phase_clock)
		else $error("strobe without byte");
	a_byte_then_data: assert property ($fell(bd[0]) |-> data_oe[7:0] == 8'hFF)
		else $error("group not driven");
	a_float_before_raise: assert property ($rose(bd[0]) |-> data_oe[7:0] == 8'h00 && !$past(data_oe[0]))
		else $error("raised before float");
	a_phase_toggles: assert property ($past(clk_en) && !$past(rst) |-> converter_phase_clock != $past(converter_phase_clock))
		else $error("phase clock stuck");
	a_next_group_follows: assert property ($rose(bd[0]) |-> s_next_group)
		else $error("next group missing");
	a_float_on_ready: assert property ($fell(data_oe[0]) |-> $past(receiver_ready_in) && !converter_phase_clock)
		else $error("float without ready");
	a_short_two_groups: assert property (short_version && ha |-> bd[2])
		else $error("third group sent");
	a_single_group: assert property ($countones(~bd) <= 1)
		else $error("two groups");
	a_pins_driven: assert property (ha |-> byte_disable_oe == 3'h7 && chip_disable_load_strobe_oe)
		else $error("pins not driven");
	a_latch_frozen: assert property (ha && $past(ha) |-> $stable(data_out))
		else $error("latched in handshake");
endmodule
bind converter_byte_handshake_port hs_port_asserts u_chk (.ref_clk, .rst, .clk_en, .short_version,
	.converter_phase_clock, .receiver_ready_in, .chip_disable_load_strobe_out, .chip_disable_load_strobe_oe,
	.byte_disable_out, .byte_disable_oe, .data_out, .data_oe, .handshake_active);
`default_nettype wire

// >>> testbench/host_port_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sb_pin,
	input wire logic [2:0] bd_pin,
	input wire logic [17:0] bus,
	input wire logic [7:0] hold,
	output logic ready,
	output logic [23:0] rx_log,
	output logic [3:0] rx_cnt
);
	logic full_q, sb_q;
	logic [7:0] wait_q;
	assign ready = !full_q;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			full_q <= 1'b0;
			sb_q <= 1'b1;
			wait_q <= 8'h00;
			rx_log <= 24'h000000;
			rx_cnt <= 4'h0;
		end else begin
			sb_q <= sb_pin;
			if (!sb_pin) begin
				full_q <= 1'b1;
				wait_q <= hold;
			end else if (!sb_q) begin
				rx_cnt <= rx_cnt + 4'h1;
				rx_log <= {rx_log[15:0], !bd_pin[0] ? bus[7:0] : !bd_pin[1] ? bus[15:8] : {6'h00, bus[17:16]}};
			end else if (full_q) begin
				if (wait_q == 8'h00) full_q <= 1'b0;
				else wait_q <= wait_q - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// >>> testbench/converter_byte_handshake_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module converter_byte_handshake_port_tb;
	logic ref_clk = 0, rst = 1, latch = 0, short_v = 0, req = 0;
	logic [17:0] res = 18'h00000;
	logic [7:0] hold = 8'h00;
	wire ph, rdy, sb_o, sb_oe, ha;
	wire [2:0] bd_o, bd_oe;
	wire [17:0] d_o, d_oe;
	wire sb_pin = sb_oe ? sb_o : 1'b1;
	wire [2:0] bd_pin = bd_o | ~bd_oe;
	wire [17:0] bus = ~(d_o ^ d_oe);
	wire [23:0] rx_log;
	wire [3:0] rx_cnt;
	int err_count = 0, cmp_count = 0, cyc = 0;
	initial forever #10 ref_clk = ~ref_clk;
	converter_byte_handshake_port u_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .result_latch(latch),
		.result_in(res), .short_version(short_v), .handshake_req(req), .converter_phase_clock(ph),
		.receiver_ready_in(rdy), .chip_disable_load_strobe_in(sb_pin), .chip_disable_load_strobe_out(sb_o),
		.chip_disable_load_strobe_oe(sb_oe), .byte_disable_in(bd_pin), .byte_disable_out(bd_o),
		.byte_disable_oe(bd_oe), .data_out(d_o), .data_oe(d_oe), .handshake_active(ha));
	host_port_model u_host (.ref_clk(ref_clk), .rst(rst), .sb_pin(sb_pin), .bd_pin(bd_pin), .bus(bus),
		.hold(hold), .ready(rdy), .rx_log(rx_log), .rx_cnt(rx_cnt));
	task summarize;
		if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s exp %h got %h", name, exp, got);
		end
	endtask
	task wait_hs;
		int n;
		n = 0;
		while (ha !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		chk("handshake start", 24'h1, ha);
		n = 0;
		while (ha !== 1'b0 && n < 900) begin
			@(negedge ref_clk);
			n++;
		end
		chk("handshake end", 24'h0, ha);
	endtask
	task latch_one(input logic [17:0] v);
		res = v;
		latch = 1;
		repeat (2) @(negedge ref_clk);
		latch = 0;
		wait_hs();
	endtask
	// steady request, full version, two conversions
	task full_stream;
		req = 1;
		latch_one(18'h3A5C3);
		chk("bytes full", 24'hC3A503, rx_log);
		latch_one(18'h2B4D2);
		chk("bytes next", 24'hD2B402, rx_log);
		chk("byte count", 24'h6, rx_cnt);
	endtask
	// request on demand, short version, slow receiver
	task demand_short;
		req = 0;
		repeat (4) @(negedge ref_clk);
		chk("disable oe", 24'h0, {bd_oe, sb_oe});
		short_v = 1;
		hold = 8'h06;
		res = 18'h1F0E1;
		latch = 1;
		@(negedge ref_clk);
		latch = 0;
		repeat (4) @(negedge ref_clk);
		chk("no handshake", 24'h0, ha);
		req = 1;
		@(negedge ref_clk);
		chk("entry", 24'h1, ha);
		res = 18'h00FFF;
		latch = 1;
		@(negedge ref_clk);
		latch = 0;
		wait_hs();
		chk("bytes short", 24'h02E1F0, rx_log);
		chk("byte count", 24'h8, rx_cnt);
	endtask
	initial begin
		repeat (3) @(negedge ref_clk);
		rst = 0;
		full_stream();
		demand_short();
		summarize();
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end
endmodule
`default_nettype wire
